// ---- core/imrsz_ctrl.v ----
/*
  Scaling control of the image resizer: registers, vertical line engine
  and horizontal sample engine. Assumes the upstream pipe and the output
  writer run on MCLK and signal with one-cycle pulses.
*/
// The implementer's own choices: the Avalon-MM register port and the register offsets.
// Summary of operation
// [RULE1] last vertical phase latched at pass end
// [RULE2] last phase valid only in confined mode
// [RULE3] vertical ratio is 256 over step
// [RULE4] produced line count readable after pass
// [RULE5] horizontal accumulator starts from programmed phase
// [RULE6] software keeps horizontal initial phase 0..8192
// [RULE7] horizontal ratio is 256 over step
// [RULE8] method bit: 0 cubic, 1 linear
// [RULE9] lpf source: 0 internal, 1 register
// [RULE10] programmed intensity applied only when selected
// [RULE11] rgb conversion only when enable set
// [RULE12] vertical phase starts from programmed initial value
// [RULE13] confined mode takes line count plus one
// [RULE14] step per sample, integer selects, fraction phases
`timescale 1ns/1ps
`default_nettype none
`include "imrsz_regs.vh"

module imrsz_ctrl (
  // clock and reset
  input wire MCLK,
  input wire SRST,
  // register bus
  input wire [7:0] AVS_ADDRESS,
  input wire AVS_READ,
  input wire AVS_WRITE,
  input wire [3:0] AVS_BYTEENABLE,
  input wire [31:0] AVS_WRITEDATA,
  output wire [31:0] AVS_READDATA,
  output wire [1:0] AVS_RESPONSE,
  output wire AVS_WAITREQUEST,
  // upstream image pipe
  input wire FRAME_START,
  input wire FRAME_END,
  input wire LINE_IN,
  input wire LINE_START,
  input wire PIX_IN,
  // vertical output toward the writer
  output wire OUT_LINE,
  output wire [12:0] OUT_VLINE,
  output wire [7:0] OUT_VPHASE,
  output wire PASS_BUSY,
  output wire PASS_DONE,
  // horizontal output samples
  output wire OUT_PIX,
  output wire [13:0] OUT_HPOS,
  output wire [7:0] OUT_HPHASE,
  // filter configuration
  output wire H_TWO_TAP,
  output wire [7:0] LPF_INTENSITY,
  output wire RGB_ENABLE
);

  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_DRAIN = 2'h2;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  reg [13:0] vstep_reg;
  reg [13:0] vinit_reg;
  reg [13:0] hinit_reg;
  reg [13:0] hstep_reg;
  reg [7:0] lpf_reg;
  reg hmethod_reg;
  reg lpfsel_reg;
  reg rgb_reg;
  reg confined_reg;
  reg [11:0] in_cnt_reg;
  reg [13:0] last_phase_reg;
  reg phase_valid_reg;
  reg [12:0] prod_reg;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg state_busy_reg;
  reg [12:0] in_lines_reg;
  reg [12:0] out_lines_reg;
  reg [13:0] last_acc_reg;
  reg hline_reg;
  reg [13:0] hpix_reg;

  reg out_line_reg;
  reg [12:0] out_vline_reg;
  reg [7:0] out_vphase_reg;
  reg done_reg;
  reg out_pix_reg;
  reg [13:0] out_hpos_reg;
  reg [7:0] out_hphase_reg;
  reg [7:0] lpf_out_reg;

  reg wait_reg;
  reg [31:0] rdata_reg;
  reg [1:0] resp_reg;
  reg [31:0] rdata_next;
  reg hit_next;

  wire [21:0] vacc;
  wire [21:0] hacc;
  wire pass_on;
  wire v_emit;
  wire line_take;
  wire last_line;
  wire h_emit;
  wire v_load;
  wire wr_fire;
  wire [13:0] in_cnt_wr;
  wire [12:0] in_limit;
  wire [13:0] hstep_over;
  wire [13:0] lpf_scaled;
  wire [7:0] lpf_internal;

  function [13:0] lanes;
    input [13:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      lanes = {(be[1] ? wd[13:8] : old[13:8]),
               (be[0] ? wd[7:0] : old[7:0])};
    end
  endfunction

  // ----------------------------------------------------------------------
  // vertical line engine
  // ----------------------------------------------------------------------
  assign pass_on = (state_reg == ST_RUN) || (state_reg == ST_DRAIN);
  assign v_load = FRAME_START && (state_reg == ST_IDLE);
  assign in_limit = {1'b0, in_cnt_reg} + 13'h0001;

  // input lines past the programmed count plus one are dropped in confined mode
  assign line_take = LINE_IN && (state_reg == ST_RUN) &&
    (!confined_reg || (in_lines_reg < in_limit)); // see [RULE13]
  assign last_line = confined_reg && line_take &&
    (in_lines_reg == {1'b0, in_cnt_reg}); // see [RULE13]

  // an output line is made once its integer position has arrived;
  // a zero step would never advance, so it makes nothing
  assign v_emit = pass_on && (vstep_reg != 14'h0000) &&
    (vacc[21:8] < {1'b0, in_lines_reg}) &&
    (out_lines_reg != 13'h1fff); // see [RULE3]

  imrsz_phase_acc u_vacc (
    .clk(MCLK),
    .rst(SRST),
    .load(v_load),
    .init(vinit_reg), // see [RULE12]
    .advance(v_emit),
    .step(vstep_reg),
    .acc(vacc)
  );

  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (FRAME_START) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (FRAME_END || last_line) begin
          state_next = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        if (!v_emit) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always @(posedge MCLK) begin
    if (SRST) begin
      state_reg <= ST_IDLE;
      in_lines_reg <= `IMRSZ_RST_COUNT;
      out_lines_reg <= `IMRSZ_RST_COUNT;
      last_acc_reg <= `IMRSZ_RST_PHASE;
      out_line_reg <= 1'b0;
      out_vline_reg <= `IMRSZ_RST_COUNT;
      out_vphase_reg <= 8'h00;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      out_line_reg <= v_emit;
      done_reg <= (state_reg == ST_DRAIN) && !v_emit;
      if (v_load) begin
        in_lines_reg <= `IMRSZ_RST_COUNT;
        out_lines_reg <= `IMRSZ_RST_COUNT;
      end else begin
        if (line_take && in_lines_reg != 13'h1fff) begin
          in_lines_reg <= in_lines_reg + 13'h0001;
        end
        if (v_emit) begin
          out_lines_reg <= out_lines_reg + 13'h0001; // see [RULE4]
        end
      end
      if (v_emit) begin
        last_acc_reg <= vacc[13:0]; // see [RULE1]
        out_vline_reg <= vacc[20:8]; // see [RULE14]
        out_vphase_reg <= vacc[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // horizontal sample engine
  // ----------------------------------------------------------------------
  assign h_emit = hline_reg && (hstep_reg != 14'h0000) &&
    (hacc[21:8] < hpix_reg); // see [RULE7]

  imrsz_phase_acc u_hacc (
    .clk(MCLK),
    .rst(SRST),
    .load(LINE_START),
    .init(hinit_reg), // see [RULE5]
    .advance(h_emit),
    .step(hstep_reg),
    .acc(hacc)
  );

  always @(posedge MCLK) begin
    if (SRST) begin
      hline_reg <= 1'b0;
      hpix_reg <= 14'h0000;
      out_pix_reg <= 1'b0;
      out_hpos_reg <= 14'h0000;
      out_hphase_reg <= 8'h00;
    end else begin
      out_pix_reg <= h_emit;
      if (LINE_START) begin
        hline_reg <= 1'b1;
        hpix_reg <= 14'h0000;
      end else if (PIX_IN && hline_reg && hpix_reg != 14'h3fff) begin
        hpix_reg <= hpix_reg + 14'h0001;
      end
      if (h_emit) begin
        out_hpos_reg <= hacc[21:8]; // see [RULE14]
        out_hphase_reg <= hacc[7:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // low-pass intensity selection
  // ----------------------------------------------------------------------
  // stronger smoothing as the shrink factor grows; unity or zoom gets none
  assign hstep_over = hstep_reg - `IMRSZ_UNITY;
  assign lpf_scaled = hstep_over >> `IMRSZ_LPF_SHIFT;
  assign lpf_internal = (hstep_reg <= `IMRSZ_UNITY) ? 8'h00 :
    ((lpf_scaled > 14'h00ff) ? 8'hff : lpf_scaled[7:0]);

  always @(posedge MCLK) begin
    if (SRST) begin
      lpf_out_reg <= `IMRSZ_RST_LPF;
    end else if (lpfsel_reg) begin
      lpf_out_reg <= lpf_reg; // see [RULE10]
    end else begin
      lpf_out_reg <= lpf_internal; // see [RULE9]
    end
  end

  // ----------------------------------------------------------------------
  // bus read decode
  // ----------------------------------------------------------------------
  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    if (AVS_ADDRESS == `IMRSZ_OFS_LAST_VPHASE) begin
      rdata_next[13:0] = last_phase_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_VSTEP) begin
      rdata_next[13:0] = vstep_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_PROD_LINES) begin
      rdata_next[12:0] = prod_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_HINIT) begin
      rdata_next[13:0] = hinit_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_HSTEP) begin
      rdata_next[13:0] = hstep_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_HMETHOD) begin
      rdata_next[0] = hmethod_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_LPF_SRC) begin
      rdata_next[0] = lpfsel_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_LPF_VAL) begin
      rdata_next[7:0] = lpf_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_RGB_EN) begin
      rdata_next[0] = rgb_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_VINIT) begin
      rdata_next[13:0] = vinit_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_IN_LINES) begin
      rdata_next[11:0] = in_cnt_reg;
    end else if (AVS_ADDRESS == `IMRSZ_OFS_SEQ) begin
      rdata_next[`IMRSZ_SEQ_CONFINED] = confined_reg;
      rdata_next[`IMRSZ_SEQ_PHASE_VALID] = phase_valid_reg;
      rdata_next[`IMRSZ_SEQ_BUSY] = pass_on;
    end else begin
      hit_next = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // bus handshake: one wait cycle, then a single accept cycle
  // ----------------------------------------------------------------------
  assign wr_fire = AVS_WRITE && !wait_reg;
  assign in_cnt_wr = lanes({2'b00, in_cnt_reg}, AVS_WRITEDATA,
    AVS_BYTEENABLE);

  always @(posedge MCLK) begin
    if (SRST) begin
      wait_reg <= 1'b1;
      rdata_reg <= 32'h00000000;
      resp_reg <= `IMRSZ_RESP_OK;
    end else begin
      wait_reg <= !((AVS_READ || AVS_WRITE) && wait_reg);
      if ((AVS_READ || AVS_WRITE) && wait_reg) begin
        resp_reg <= hit_next ? `IMRSZ_RESP_OK : `IMRSZ_RESP_SLVERR;
        rdata_reg <= AVS_READ ? rdata_next : 32'h00000000;
      end
    end
  end

  // ----------------------------------------------------------------------
  // register writes and pass status
  // ----------------------------------------------------------------------
  always @(posedge MCLK) begin
    if (SRST) begin
      vstep_reg <= `IMRSZ_RST_STEP;
      vinit_reg <= `IMRSZ_RST_PHASE;
      hinit_reg <= `IMRSZ_RST_PHASE;
      hstep_reg <= `IMRSZ_RST_STEP;
      lpf_reg <= `IMRSZ_RST_LPF;
      hmethod_reg <= 1'b0;
      lpfsel_reg <= 1'b0;
      rgb_reg <= 1'b0;
      confined_reg <= 1'b0;
      in_cnt_reg <= `IMRSZ_RST_IN_LINES;
      last_phase_reg <= `IMRSZ_RST_PHASE;
      phase_valid_reg <= 1'b0;
      prod_reg <= `IMRSZ_RST_COUNT;
    end else begin
      if (wr_fire) begin
        if (AVS_ADDRESS == `IMRSZ_OFS_LAST_VPHASE) begin
          last_phase_reg <= lanes(last_phase_reg, AVS_WRITEDATA,
            AVS_BYTEENABLE);
        end else if (AVS_ADDRESS == `IMRSZ_OFS_VSTEP) begin
          vstep_reg <= lanes(vstep_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (AVS_ADDRESS == `IMRSZ_OFS_HINIT) begin
          hinit_reg <= lanes(hinit_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (AVS_ADDRESS == `IMRSZ_OFS_HSTEP) begin
          hstep_reg <= lanes(hstep_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (AVS_ADDRESS == `IMRSZ_OFS_HMETHOD) begin
          if (AVS_BYTEENABLE[0]) begin
            hmethod_reg <= AVS_WRITEDATA[0]; // see [RULE8]
          end
        end else if (AVS_ADDRESS == `IMRSZ_OFS_LPF_SRC) begin
          if (AVS_BYTEENABLE[0]) begin
            lpfsel_reg <= AVS_WRITEDATA[0];
          end
        end else if (AVS_ADDRESS == `IMRSZ_OFS_LPF_VAL) begin
          if (AVS_BYTEENABLE[0]) begin
            lpf_reg <= AVS_WRITEDATA[7:0];
          end
        end else if (AVS_ADDRESS == `IMRSZ_OFS_RGB_EN) begin
          if (AVS_BYTEENABLE[0]) begin
            rgb_reg <= AVS_WRITEDATA[0]; // see [RULE11]
          end
        end else if (AVS_ADDRESS == `IMRSZ_OFS_VINIT) begin
          vinit_reg <= lanes(vinit_reg, AVS_WRITEDATA, AVS_BYTEENABLE);
        end else if (AVS_ADDRESS == `IMRSZ_OFS_IN_LINES) begin
          in_cnt_reg <= in_cnt_wr[11:0];
        end else if (AVS_ADDRESS == `IMRSZ_OFS_SEQ) begin
          if (AVS_BYTEENABLE[0]) begin
            confined_reg <= AVS_WRITEDATA[`IMRSZ_SEQ_CONFINED];
          end
        end
      end
      // pass completion wins over a software write in the same cycle
      if ((state_reg == ST_DRAIN) && !v_emit) begin
        last_phase_reg <= last_acc_reg; // see [RULE1]
        phase_valid_reg <= confined_reg; // see [RULE2]
        prod_reg <= out_lines_reg; // see [RULE4]
      end
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign AVS_READDATA = rdata_reg;
  assign AVS_RESPONSE = resp_reg;
  assign AVS_WAITREQUEST = wait_reg;
  assign OUT_LINE = out_line_reg;
  assign OUT_VLINE = out_vline_reg;
  assign OUT_VPHASE = out_vphase_reg;
  assign PASS_DONE = done_reg;
  assign OUT_PIX = out_pix_reg;
  assign OUT_HPOS = out_hpos_reg;
  assign OUT_HPHASE = out_hphase_reg;
  assign H_TWO_TAP = hmethod_reg;
  assign LPF_INTENSITY = lpf_out_reg;
  assign RGB_ENABLE = rgb_reg;
  assign PASS_BUSY = state_busy_reg;

  always @(posedge MCLK) begin
    if (SRST) begin
      state_busy_reg <= 1'b0;
    end else begin
      state_busy_reg <= (state_next == ST_RUN) || (state_next == ST_DRAIN);
    end
  end

endmodule

`default_nettype wire

// ---- pkg/imrsz_regs.vh ----
/*
  Register map, reset values and field positions of the resizer scaling
  control block. Definitions only; included by bare name from core files.
*/
`ifndef IMRSZ_REGS_VH
`define IMRSZ_REGS_VH

// ----------------------------------------------------------------------
// byte offsets on the register bus
// ----------------------------------------------------------------------
`define IMRSZ_OFS_LAST_VPHASE 8'h00
`define IMRSZ_OFS_VSTEP 8'h04
`define IMRSZ_OFS_PROD_LINES 8'h08
`define IMRSZ_OFS_HINIT 8'h0c
`define IMRSZ_OFS_HSTEP 8'h10
`define IMRSZ_OFS_HMETHOD 8'h14
`define IMRSZ_OFS_LPF_SRC 8'h18
`define IMRSZ_OFS_LPF_VAL 8'h1c
`define IMRSZ_OFS_RGB_EN 8'h20
`define IMRSZ_OFS_VINIT 8'h24
`define IMRSZ_OFS_IN_LINES 8'h28
`define IMRSZ_OFS_SEQ 8'h2c

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define IMRSZ_RST_STEP 14'h0100
`define IMRSZ_RST_PHASE 14'h0000
`define IMRSZ_RST_LPF 8'h00
`define IMRSZ_RST_IN_LINES 12'h000
`define IMRSZ_RST_COUNT 13'h0000

// ----------------------------------------------------------------------
// fields and scaling constants
// ----------------------------------------------------------------------
`define IMRSZ_SEQ_CONFINED 0
`define IMRSZ_SEQ_PHASE_VALID 1
`define IMRSZ_SEQ_BUSY 2
`define IMRSZ_UNITY 14'h0100
`define IMRSZ_FRAC_BITS 8
`define IMRSZ_LPF_SHIFT 4
`define IMRSZ_RESP_OK 2'h0
`define IMRSZ_RESP_SLVERR 2'h2

`endif

// ---- core/imrsz_phase_acc.v ----
/*
  Phase accumulator shared by the vertical and horizontal resize paths.
  Assumes load and advance come from logic on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

module imrsz_phase_acc (
  // clock and reset
  input wire clk,
  input wire rst,
  // control
  input wire load,
  input wire [13:0] init,
  input wire advance,
  input wire [13:0] step,
  // state: integer part from bit 8 up, filter phase below
  output wire [21:0] acc
);

  reg [21:0] acc_reg;
  reg [21:0] acc_next;

  // ----------------------------------------------------------------------
  // accumulate
  // ----------------------------------------------------------------------
  always @* begin
    acc_next = acc_reg;
    if (load) begin
      acc_next = {8'h00, init};
    end else if (advance) begin
      // wraps silently; a pass of 16k lines at step 256 is the ceiling
      acc_next = acc_reg + {8'h00, step}; // see [RULE14]
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      acc_reg <= 22'h000000;
    end else begin
      acc_reg <= acc_next;
    end
  end

  assign acc = acc_reg;

endmodule

`default_nettype wire

// ---- sim/imrsz_props.sv ----
/*
  Port assertions for the resizer scaling control block.
  Assumes a bind into imrsz_ctrl: one clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
`include "imrsz_regs.vh"

module imrsz_props (
  // clock and reset
  input wire logic MCLK,
  input wire logic SRST,
  // register bus
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [31:0] AVS_READDATA,
  input wire logic [1:0] AVS_RESPONSE,
  input wire logic AVS_WAITREQUEST,
  // stream and filter setup
  input wire logic FRAME_START,
  input wire logic OUT_LINE,
  input wire logic [12:0] OUT_VLINE,
  input wire logic [7:0] OUT_VPHASE,
  input wire logic PASS_BUSY,
  input wire logic PASS_DONE,
  input wire logic H_TWO_TAP,
  input wire logic RGB_ENABLE
);
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (SRST);

  // --------------------------------
  // bus helpers
  // --------------------------------
  wire req = AVS_READ | AVS_WRITE;
  wire hit = req & ~AVS_WAITREQUEST;
  wire rdh = hit & AVS_READ;
  wire wrh = hit & AVS_WRITE & AVS_BYTEENABLE[0];
  wire unmap = (AVS_ADDRESS > `IMRSZ_OFS_SEQ) || (AVS_ADDRESS[1:0] != 2'h0);

  AST_WAIT_DROP: assert property (req && AVS_WAITREQUEST
    |=> !AVS_WAITREQUEST) else $error("no answer after one wait cycle");
  AST_WAIT_ONE: assert property (!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low for more than one cycle");
  AST_UNMAPPED: assert property (rdh && unmap |-> AVS_READDATA == 32'h0
    && AVS_RESPONSE == `IMRSZ_RESP_SLVERR) else $error("unmapped read");
  AST_MAPPED: assert property (rdh && !unmap |-> AVS_READDATA[31:16]
    == 16'h0 && AVS_RESPONSE == `IMRSZ_RESP_OK) else $error("mapped read");
  AST_COUNT_W: assert property (
    rdh && AVS_ADDRESS == `IMRSZ_OFS_PROD_LINES |-> AVS_READDATA[31:13]
    == 19'h0) else $error("line count wider than 13 bits");
  AST_PHASE_W: assert property (
    rdh && AVS_ADDRESS == `IMRSZ_OFS_LAST_VPHASE |-> AVS_READDATA[31:14]
    == 18'h0) else $error("last phase wider than 14 bits");
  AST_BUSY_START: assert property (
    FRAME_START && !PASS_BUSY |=> PASS_BUSY) else $error("pass not started");
  AST_DONE_PULSE: assert property (PASS_DONE |=> !PASS_DONE)
    else $error("pass done longer than one cycle");
  AST_LINE_BUSY: assert property (OUT_LINE |-> PASS_BUSY)
    else $error("output line outside a pass");
  AST_LINE_HOLD: assert property (
    !OUT_LINE |-> $stable(OUT_VLINE) && $stable(OUT_VPHASE))
    else $error("line position moved without a line");
  AST_METHOD: assert property (
    wrh && AVS_ADDRESS == `IMRSZ_OFS_HMETHOD ##1 1'b1
    |=> H_TWO_TAP == $past(AVS_WRITEDATA[0], 2)) else $error("method bit");
  AST_RGB: assert property (
    wrh && AVS_ADDRESS == `IMRSZ_OFS_RGB_EN ##1 1'b1
    |=> RGB_ENABLE == $past(AVS_WRITEDATA[0], 2)) else $error("rgb enable");
endmodule

bind imrsz_ctrl imrsz_props u_props (.MCLK, .SRST, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_RESPONSE,
  .AVS_WAITREQUEST, .FRAME_START, .OUT_LINE, .OUT_VLINE, .OUT_VPHASE,
  .PASS_BUSY, .PASS_DONE, .H_TWO_TAP, .RGB_ENABLE);
`default_nettype wire

// ---- sim/imrsz_pipe.sv ----
/*
  Upstream image pipe model: one-cycle strobes on MCLK.
  Assumes the bench calls run right after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none

module imrsz_pipe (
  // clock
  input wire logic clk,
  // strobes: pixel, line start, line, frame end, frame start
  output logic [4:0] pulses
);
  initial pulses = 5'h00;

  // gap of at least one edge keeps each strobe a clean single pulse;
  // frame order is left to the caller
  task run(input int k, input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      pulses[k] <= 1'b1;
      @(posedge clk);
      pulses[k] <= 1'b0;
      repeat (gap) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// ---- sim/tb_top.sv ----
/*
  Self-checking bench for imrsz_ctrl: registers, vertical and
  horizontal passes, filter setup. Assumes imrsz_pipe drives strobes.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic MCLK = 1'b0;
  logic SRST = 1'b1;
  logic [7:0] AVS_ADDRESS = 8'h00;
  logic AVS_READ = 1'b0;
  logic AVS_WRITE = 1'b0;
  logic [3:0] AVS_BYTEENABLE = 4'hf;
  logic [31:0] AVS_WRITEDATA = 32'h0;
  wire [31:0] AVS_READDATA;
  wire [1:0] AVS_RESPONSE;
  wire AVS_WAITREQUEST, FRAME_START, FRAME_END, LINE_IN, LINE_START;
  wire PIX_IN, OUT_LINE, PASS_BUSY, PASS_DONE, OUT_PIX, H_TWO_TAP;
  wire RGB_ENABLE;
  wire [12:0] OUT_VLINE;
  wire [7:0] OUT_VPHASE, OUT_HPHASE, LPF_INTENSITY;
  wire [13:0] OUT_HPOS;
  int n_errors = 0;
  int checks_done = 0;
  int n_done, n_line, n_pix;
  logic [31:0] rq;
  logic [13:0] fpos;
  logic [7:0] fph;
  logic [20:0] lvp;

  // writable registers in offset order; the read-only count is skipped
  function automatic logic [7:0] radr(input int k);
    return 8'((k < 2) ? k * 4 : k * 4 + 4);
  endfunction

  function automatic logic [15:0] rmsk(input int k);
    case (k)
      4, 5, 7, 10: return 16'h0001;
      6: return 16'h00ff;
      9: return 16'h0fff;
      default: return 16'h3fff;
    endcase
  endfunction

  always #50 MCLK = ~MCLK;

  imrsz_ctrl DUT (.MCLK, .SRST, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE,
    .AVS_BYTEENABLE, .AVS_WRITEDATA, .AVS_READDATA, .AVS_RESPONSE,
    .AVS_WAITREQUEST, .FRAME_START, .FRAME_END, .LINE_IN, .LINE_START,
    .PIX_IN, .OUT_LINE, .OUT_VLINE, .OUT_VPHASE, .PASS_BUSY, .PASS_DONE,
    .OUT_PIX, .OUT_HPOS, .OUT_HPHASE, .H_TWO_TAP, .LPF_INTENSITY,
    .RGB_ENABLE);
  imrsz_pipe pipe (.clk(MCLK),
    .pulses({PIX_IN, LINE_START, LINE_IN, FRAME_END, FRAME_START}));

  always @(posedge MCLK) begin
    if (PASS_DONE === 1'b1) n_done++;
    if (OUT_LINE === 1'b1) begin
      n_line++;
      lvp = {OUT_VLINE, OUT_VPHASE};
    end
    if (OUT_PIX === 1'b1) begin
      if (n_pix == 0) begin
        fpos = OUT_HPOS;
        fph = OUT_HPHASE;
      end
      n_pix++;
    end
  end

  // --------------------------------
  // shared tasks
  // --------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // one idle edge first, so a release never meets a new request
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge MCLK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_WRITE <= w;
    AVS_READ <= !w;
    i = 0;
    @(posedge MCLK);
    while (AVS_WAITREQUEST !== 1'b0 && i < 40) begin
      @(posedge MCLK);
      i++;
    end
    rq = AVS_READDATA;
    AVS_WRITE <= 1'b0;
    AVS_READ <= 1'b0;
    if (i >= 40) chk("bus answer", 32'h0, 32'h1);
  endtask

  task wait_done;
    int i;
    i = 0;
    while (n_done == 0 && i < 600) begin
      @(posedge MCLK);
      i++;
    end
    chk("pass done", 32'h1, 32'(n_done));
    repeat (4) @(posedge MCLK);
  endtask

  // --------------------------------
  // scenarios
  // --------------------------------
  task t_regs;
    for (int k = 0; k < 11; k++) begin
      bus(1'b0, radr(k), 32'h0);
      chk("reset value", (k == 1 || k == 3) ? 32'h100 : 32'h0, rq);
      bus(1'b1, radr(k), 32'hffffffff);
      bus(1'b0, radr(k), 32'h0);
      chk("field mask", 32'(rmsk(k)), rq);
      bus(1'b1, radr(k), 32'h0);
    end
    bus(1'b1, 8'h08, 32'h1fff);
    bus(1'b0, 8'h08, 32'h0);
    chk("read-only count", 32'h0, rq);
    bus(1'b1, 8'h40, 32'h1);
    bus(1'b0, 8'h30, 32'h0);
    chk("unmapped resp", 32'h2, 32'(AVS_RESPONSE));
    AVS_BYTEENABLE <= 4'h1;
    bus(1'b1, 8'h0c, 32'hffff);
    AVS_BYTEENABLE <= 4'hf;
    bus(1'b0, 8'h0c, 32'h0);
    chk("byte lane", 32'h00ff, rq);
    bus(1'b1, 8'h0c, 32'h0);
    $display("test regs done");
  endtask

  task t_filt;
    for (int b = 1; b >= 0; b--) begin
      bus(1'b1, 8'h14, 32'(b));
      bus(1'b1, 8'h20, 32'(b));
      repeat (2) @(posedge MCLK);
      chk("two tap", 32'(b), 32'(H_TWO_TAP));
      chk("rgb enable", 32'(b), 32'(RGB_ENABLE));
    end
    bus(1'b1, 8'h10, 32'h100);
    bus(1'b1, 8'h1c, 32'h5a);
    repeat (2) @(posedge MCLK);
    chk("lpf internal", 32'h0, 32'(LPF_INTENSITY));
    bus(1'b1, 8'h18, 32'h1);
    repeat (2) @(posedge MCLK);
    chk("lpf register", 32'h5a, 32'(LPF_INTENSITY));
    bus(1'b1, 8'h18, 32'h0);
    bus(1'b1, 8'h10, 32'h200);
    repeat (2) @(posedge MCLK);
    chk("lpf derived", 32'h10, 32'(LPF_INTENSITY));
    $display("test filter done");
  endtask

  task t_vert(input int st, input int vi, input int n, input int cf,
    input int cl, input int gap);
    int nn, k;
    nn = (cf != 0 && cl + 1 < n) ? cl + 1 : n;
    k = (nn * 256 - vi + st - 1) / st;
    bus(1'b1, 8'h04, 32'(st));
    bus(1'b1, 8'h24, 32'(vi));
    bus(1'b1, 8'h2c, 32'(cf));
    bus(1'b1, 8'h28, 32'(cl));
    n_done = 0;
    n_line = 0;
    pipe.run(0, 1, 1);
    pipe.run(2, n, gap);
    pipe.run(1, 1, 1);
    wait_done;
    chk("line pulses", 32'(k), 32'(n_line));
    chk("last line pos", 32'(vi + (k - 1) * st), 32'(lvp));
    bus(1'b0, 8'h08, 32'h0);
    chk("line count", 32'(k), rq);
    bus(1'b0, 8'h00, 32'h0);
    chk("last phase", 32'((vi + (k - 1) * st) & 16'h3fff), rq);
    bus(1'b0, 8'h2c, 32'h0);
    chk("phase valid", 32'(cf), 32'(rq[1]));
    $display("test vertical step %0d done", st);
  endtask

  task t_horiz(input int hi, input int st, input int p);
    bus(1'b1, 8'h0c, 32'(hi));
    bus(1'b1, 8'h10, 32'(st));
    n_done = 0;
    n_pix = 0;
    pipe.run(0, 1, 1);
    pipe.run(3, 1, 1);
    pipe.run(4, p, 2);
    pipe.run(1, 1, 1);
    wait_done;
    chk("pix", 32'((p * 256 - hi + st - 1) / st), 32'(n_pix));
    chk("first position", 32'(hi >> 8), 32'(fpos));
    chk("first phase", 32'(hi & 255), 32'(fph));
    $display("test horizontal start %0d done", hi);
  endtask

  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (6) @(posedge MCLK);
    SRST <= 1'b0;
    t_regs;
    t_filt;
    t_vert(256, 0, 4, 0, 0, 1);
    t_vert(512, 0, 6, 0, 0, 4);
    t_vert(128, 0, 3, 0, 0, 1);
    t_vert(256, 128, 3, 0, 0, 2);
    t_vert(256, 0, 6, 1, 2, 1);
    t_horiz(0, 256, 5);
    t_horiz(384, 512, 8);
    t_horiz(8192, 256, 40);
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge MCLK);
    n_errors++;
    end_sim;
  end
endmodule
`default_nettype wire
